// ===== verilog/zero_ofs_pkg.sv
// Constants, types and register map of the zero offset programming controller
package zero_ofs_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned PROG_WAIT_MS = 30;
  localparam int unsigned PROG_WAIT_CYCLES = PROG_WAIT_MS * (CLK_HZ / 1000);
  localparam int unsigned SSI_RECOVERY_NS = 20000;
  localparam int unsigned SSI_RECOVERY_CYCLES =
    (SSI_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SSI_HALF_CYCLES = 5;
  localparam int unsigned SPI_HALF_CYCLES = 5;

  // Widths
  localparam int unsigned POS_BITS = 25;
  localparam int unsigned OFS_BITS = 24;
  localparam int unsigned SPI_FRAME_BITS = 16;

  // Resolution select codes and bit counts of the position word
  localparam logic [1:0] RES_25 = 2'h0;
  localparam logic [1:0] RES_23 = 2'h1;
  localparam logic [1:0] RES_21 = 2'h2;
  localparam logic [1:0] RES_17 = 2'h3;
  localparam logic [4:0] NBITS_25 = 5'h19;
  localparam logic [4:0] NBITS_23 = 5'h17;
  localparam logic [4:0] NBITS_21 = 5'h15;
  localparam logic [4:0] NBITS_17 = 5'h11;

  // Device register addresses and key values
  localparam logic SPI_WR_FLAG = 1'b0;
  localparam logic [6:0] PAGE_SEL_ADDR = 7'h7F;
  localparam logic [7:0] PAGE_CFG = 8'h08;
  localparam logic [6:0] UNLOCK_ADDR = 7'h00;
  localparam logic [7:0] UNLOCK_KEY = 8'hAB;
  localparam logic [7:0] PAGE_OFS = 8'h0E;
  localparam logic [6:0] OFS_LOW_ADDR = 7'h0C;
  localparam logic [6:0] OFS_MID_ADDR = 7'h0D;
  localparam logic [6:0] OFS_HIGH_ADDR = 7'h0E;
  localparam logic [6:0] NV_UNLOCK_ADDR = 7'h1B;
  localparam logic [7:0] NV_UNLOCK_KEY = 8'h0F;
  localparam logic [6:0] NV_PROG_ADDR = 7'h40;
  localparam logic [7:0] NV_PROG_CMD = 8'hC0;
  localparam logic [2:0] LAST_STEP = 3'h7;

  // Controller register map (byte addresses)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_OFFSET = 4'h8;
  localparam logic [3:0] REG_POSITION = 4'hC;
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_STILL = 1;
  localparam int unsigned CTRL_RES_LSB = 4;
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_DONE = 1;
  localparam int unsigned STAT_REFUSED = 2;
  localparam int unsigned STAT_ZERO_OK = 3;
  localparam int unsigned STAT_STATE_LSB = 8;
  localparam logic [1:0] CTRL_RES_RESET = 2'h0;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } spi_cmd_t;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
  } spi_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CAPTURE = 3'h1,
    ST_SPI_ISSUE = 3'h2,
    ST_SPI_WAIT = 3'h3,
    ST_SETTLE = 3'h4,
    ST_VERIFY = 3'h5
  } seq_state_t;
endpackage

// ===== verilog/spi_write_engine.sv
// SPI mode 0 write engine: one 16-bit frame of flag, address and data
`timescale 1ns/1ps
module spi_write_engine #(
  parameter int unsigned HALF_CYCLES = zero_ofs_pkg::SPI_HALF_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // Command
  input wire logic start_in,
  input wire zero_ofs_pkg::spi_cmd_t cmd_in,
  output logic busy_out,
  output logic done_out,
  // Pins
  output zero_ofs_pkg::spi_pins_t spi_out
);
  import zero_ofs_pkg::*;

  logic [SPI_FRAME_BITS-1:0] shift_reg;
  logic [4:0] bit_reg;
  logic [7:0] div_reg;
  logic tail_reg;

  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      busy_out <= 1'b0;
      done_out <= 1'b0;
      spi_out <= '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
      shift_reg <= '0;
      bit_reg <= '0;
      div_reg <= '0;
      tail_reg <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      if (!busy_out)
      begin
        if (start_in)
        begin
          busy_out <= 1'b1;
          shift_reg <= {SPI_WR_FLAG, cmd_in.addr, cmd_in.data};
          spi_out.cs_n <= 1'b0;
          spi_out.mosi <= SPI_WR_FLAG;
          bit_reg <= '0;
          div_reg <= '0;
          tail_reg <= 1'b0;
        end
      end
      else if (div_reg != 8'(HALF_CYCLES - 1))
        div_reg <= div_reg + 8'h01;
      else
      begin
        div_reg <= '0;
        // Keep chip select high a half period between frames
        if (tail_reg)
        begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end
        else if (!spi_out.sclk)
          spi_out.sclk <= 1'b1;
        else
        begin
          spi_out.sclk <= 1'b0;
          if (bit_reg == 5'(SPI_FRAME_BITS - 1))
          begin
            spi_out.cs_n <= 1'b1;
            tail_reg <= 1'b1;
          end
          else
          begin
            bit_reg <= bit_reg + 5'h01;
            shift_reg <= {shift_reg[SPI_FRAME_BITS-2:0], 1'b0};
            spi_out.mosi <= shift_reg[SPI_FRAME_BITS-2];
          end
        end
      end
    end
  end
endmodule

// ===== verilog/zero_offset_host.sv
// Host controller: captures position over SSI and programs the zero offset over SPI
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
module zero_offset_host #(
  parameter int unsigned PROG_WAIT_CYCLES = zero_ofs_pkg::PROG_WAIT_CYCLES,
  parameter int unsigned SSI_HALF_CYCLES = zero_ofs_pkg::SSI_HALF_CYCLES,
  parameter int unsigned SSI_RECOVERY_CYCLES = zero_ofs_pkg::SSI_RECOVERY_CYCLES,
  parameter int unsigned SPI_HALF_CYCLES = zero_ofs_pkg::SPI_HALF_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // SSI position link
  output logic ssi_clk_out,
  input wire logic ssi_data_in,
  // SPI configuration link
  output zero_ofs_pkg::spi_pins_t spi_out
);
  import zero_ofs_pkg::*;

  seq_state_t state_reg;
  logic [2:0] step_reg;
  logic [OFS_BITS-1:0] zero_offset_value;
  logic [POS_BITS-1:0] raw_pos_reg;
  logic [31:0] wait_cnt_reg;
  logic ssi_go_reg;
  logic spi_start_reg;
  spi_cmd_t spi_cmd_reg;
  logic spi_busy;
  logic spi_done;
  logic done_reg;
  logic refused_reg;
  logic zero_ok_reg;
  logic still_reg;
  logic [1:0] res_reg;
  logic start_pulse_reg;
  logic [31:0] rd_next;
  logic accept;
  logic [1:0] stat_clr;

  // SSI reader state
  logic ssi_busy_reg;
  logic ssi_done_reg;
  logic ssi_rec_reg;
  logic [4:0] ssi_cnt_reg;
  logic [7:0] ssi_div_reg;
  logic [15:0] ssi_rec_cnt_reg;
  logic [POS_BITS-1:0] pos_shift_reg;
  logic [4:0] nbits;
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic data_lvl_reg;

  function automatic logic [OFS_BITS-1:0] normalise(input logic [POS_BITS-1:0] raw,
                                                    input logic [1:0] res);
    logic [OFS_BITS:0] wide;
    wide = '0;
    case (res)
      RES_25: wide = raw;
      RES_23: wide = {raw[22:0], 2'h0};
      RES_21: wide = {raw[20:0], 4'h0};
      default: wide = {raw[16:0], 8'h00};
    endcase
    // Widened to 25 bits, the LSB is dropped as for a native 25-bit reading
    return wide[OFS_BITS:1];
  endfunction

  function automatic spi_cmd_t step_cmd(input logic [2:0] step,
                                        input logic [OFS_BITS-1:0] ofs);
    spi_cmd_t c;
    c = '{addr: PAGE_SEL_ADDR, data: PAGE_CFG};
    case (step)
      3'h1: c = '{addr: UNLOCK_ADDR, data: UNLOCK_KEY};
      3'h2: c = '{addr: PAGE_SEL_ADDR, data: PAGE_OFS};
      3'h3: c = '{addr: OFS_LOW_ADDR, data: ofs[7:0]};
      3'h4: c = '{addr: OFS_MID_ADDR, data: ofs[15:8]};
      3'h5: c = '{addr: OFS_HIGH_ADDR, data: ofs[23:16]};
      3'h6: c = '{addr: NV_UNLOCK_ADDR, data: NV_UNLOCK_KEY};
      3'h7: c = '{addr: NV_PROG_ADDR, data: NV_PROG_CMD};
      default: c = '{addr: PAGE_SEL_ADDR, data: PAGE_CFG};
    endcase
    return c;
  endfunction

  always_comb
  begin
    case (res_reg)
      RES_25: nbits = NBITS_25;
      RES_23: nbits = NBITS_23;
      RES_21: nbits = NBITS_21;
      default: nbits = NBITS_17;
    endcase
  end

  // Bus slave: one wait cycle, then the answer
  assign accept = (avs_read_in || avs_write_in) && avs_waitrequest_out;
  assign stat_clr = (accept && avs_write_in && avs_address_in == REG_STATUS
                     && avs_byteenable_in[0]) ?
                    {avs_writedata_in[STAT_REFUSED], avs_writedata_in[STAT_DONE]} : 2'h0;

  always_comb
  begin
    rd_next = '0;
    if (avs_address_in == REG_CTRL)
    begin
      rd_next[CTRL_STILL] = still_reg;
      rd_next[CTRL_RES_LSB +: 2] = res_reg;
    end
    else if (avs_address_in == REG_STATUS)
    begin
      rd_next[STAT_BUSY] = (state_reg != ST_IDLE);
      rd_next[STAT_DONE] = done_reg;
      rd_next[STAT_REFUSED] = refused_reg;
      rd_next[STAT_ZERO_OK] = zero_ok_reg;
      rd_next[STAT_STATE_LSB +: 3] = state_reg;
    end
    else if (avs_address_in == REG_OFFSET)
      rd_next[OFS_BITS-1:0] = zero_offset_value;
    else if (avs_address_in == REG_POSITION)
      rd_next[POS_BITS-1:0] = raw_pos_reg;
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= '0;
    end
    else if (accept)
    begin
      avs_waitrequest_out <= 1'b0;
      if (avs_read_in)
        avs_readdata_out <= rd_next;
    end
    else
      avs_waitrequest_out <= 1'b1;
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      still_reg <= 1'b0;
      res_reg <= CTRL_RES_RESET;
      start_pulse_reg <= 1'b0;
    end
    else
    begin
      start_pulse_reg <= 1'b0;
      if (accept && avs_write_in && avs_address_in == REG_CTRL && avs_byteenable_in[0])
      begin
        still_reg <= avs_writedata_in[CTRL_STILL];
        res_reg <= avs_writedata_in[CTRL_RES_LSB +: 2];
        start_pulse_reg <= avs_writedata_in[CTRL_START];
      end
    end
  end

  // Position input: three flops, a change counts once the last two agree
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      sync3_reg <= 1'b1;
      data_lvl_reg <= 1'b1;
    end
    else
    begin
      sync1_reg <= ssi_data_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (sync2_reg == sync3_reg)
        data_lvl_reg <= sync3_reg;
    end
  end

  // SSI read: first falling edge latches, then one bit per falling edge
  // Half period must exceed the input filter delay of four cycles
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ssi_busy_reg <= 1'b0;
      ssi_done_reg <= 1'b0;
      ssi_rec_reg <= 1'b0;
      ssi_clk_out <= 1'b1;
      ssi_cnt_reg <= '0;
      ssi_div_reg <= '0;
      ssi_rec_cnt_reg <= '0;
      pos_shift_reg <= '0;
    end
    else
    begin
      ssi_done_reg <= 1'b0;
      if (!ssi_busy_reg)
      begin
        if (ssi_go_reg)
        begin
          ssi_busy_reg <= 1'b1;
          ssi_rec_reg <= 1'b0;
          ssi_cnt_reg <= '0;
          ssi_div_reg <= '0;
          ssi_rec_cnt_reg <= '0;
          pos_shift_reg <= '0;
        end
      end
      else if (ssi_rec_reg)
      begin
        if (ssi_rec_cnt_reg == 16'(SSI_RECOVERY_CYCLES - 1))
        begin
          ssi_busy_reg <= 1'b0;
          ssi_done_reg <= 1'b1;
        end
        else
          ssi_rec_cnt_reg <= ssi_rec_cnt_reg + 16'h0001;
      end
      else if (ssi_div_reg != 8'(SSI_HALF_CYCLES - 1))
        ssi_div_reg <= ssi_div_reg + 8'h01;
      else
      begin
        ssi_div_reg <= '0;
        ssi_clk_out <= ~ssi_clk_out;
        if (ssi_clk_out)
        begin
          ssi_cnt_reg <= ssi_cnt_reg + 5'h01;
          if (ssi_cnt_reg != 5'h00)
            pos_shift_reg <= {pos_shift_reg[POS_BITS-2:0], data_lvl_reg};
        end
        else if (ssi_cnt_reg == nbits + 5'h01)
          ssi_rec_reg <= 1'b1;
      end
    end
  end

  // Programming sequence
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_reg <= ST_IDLE;
      step_reg <= '0;
      zero_offset_value <= '0;
      raw_pos_reg <= '0;
      wait_cnt_reg <= '0;
      ssi_go_reg <= 1'b0;
      spi_start_reg <= 1'b0;
      spi_cmd_reg <= '0;
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
      zero_ok_reg <= 1'b0;
    end
    else
    begin
      ssi_go_reg <= 1'b0;
      spi_start_reg <= 1'b0;
      // Clear first so a same-cycle event wins
      if (stat_clr[0])
        done_reg <= 1'b0;
      if (stat_clr[1])
        refused_reg <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (start_pulse_reg)
          begin
            if (!still_reg)
              refused_reg <= 1'b1;
            else
            begin
              ssi_go_reg <= 1'b1;
              done_reg <= 1'b0;
              zero_ok_reg <= 1'b0;
              state_reg <= ST_CAPTURE;
            end
          end
        end
        ST_CAPTURE:
        begin
          if (ssi_done_reg)
          begin
            raw_pos_reg <= pos_shift_reg;
            zero_offset_value <= normalise(pos_shift_reg, res_reg);
            step_reg <= '0;
            state_reg <= ST_SPI_ISSUE;
          end
        end
        ST_SPI_ISSUE:
        begin
          if (!spi_busy)
          begin
            spi_cmd_reg <= step_cmd(step_reg, zero_offset_value);
            spi_start_reg <= 1'b1;
            state_reg <= ST_SPI_WAIT;
          end
        end
        ST_SPI_WAIT:
        begin
          if (spi_done)
          begin
            if (step_reg == LAST_STEP)
            begin
              wait_cnt_reg <= '0;
              state_reg <= ST_SETTLE;
            end
            else
            begin
              step_reg <= step_reg + 3'h1;
              state_reg <= ST_SPI_ISSUE;
            end
          end
        end
        ST_SETTLE:
        begin
          if (wait_cnt_reg == PROG_WAIT_CYCLES - 1)
          begin
            ssi_go_reg <= 1'b1;
            state_reg <= ST_VERIFY;
          end
          else
            wait_cnt_reg <= wait_cnt_reg + 32'h00000001;
        end
        ST_VERIFY:
        begin
          if (ssi_done_reg)
          begin
            raw_pos_reg <= pos_shift_reg;
            zero_ok_reg <= (pos_shift_reg == '0);
            done_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  spi_write_engine #(
    .HALF_CYCLES(SPI_HALF_CYCLES)
  ) u_spi (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .start_in(spi_start_reg),
    .cmd_in(spi_cmd_reg),
    .busy_out(spi_busy),
    .done_out(spi_done),
    .spi_out(spi_out)
  );
endmodule

// ===== sim/zero_offset_host_assertions.sv
// Port checks for the zero offset host
`timescale 1ns/1ps
module zero_offset_host_assertions (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // Watched ports
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic ssi_clk_out,
  input wire zero_ofs_pkg::spi_pins_t spi_out
);
  import zero_ofs_pkg::*;
  logic sclk_reg;
  logic [4:0] bits_reg;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      sclk_reg <= 1'b0;
      bits_reg <= 5'h00;
    end
    else
    begin
      sclk_reg <= spi_out.sclk;
      if (spi_out.cs_n)
        bits_reg <= 5'h00;
      else if (spi_out.sclk && !sclk_reg)
        bits_reg <= bits_reg + 5'h01;
    end
  end
  sequence frame_open;
    $fell(spi_out.cs_n);
  endsequence
  sequence frame_held;
    !spi_out.cs_n [*8];
  endsequence
  bus_answer_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("bus answer late");
  answer_once_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer held too long");
  sclk_idle_a: assert property (spi_out.cs_n |-> !spi_out.sclk)
    else $error("clock outside frame");
  frame_bits_a: assert property ($rose(spi_out.cs_n) |-> bits_reg == 5'h10)
    else $error("frame length wrong");
  write_flag_a: assert property (!spi_out.cs_n && spi_out.sclk && !sclk_reg
    && bits_reg == 5'h00 |-> !spi_out.mosi) else $error("not a write frame");
  mosi_hold_a: assert property (spi_out.sclk && sclk_reg |-> $stable(spi_out.mosi))
    else $error("data moved while clock high");
  frame_hold_a: assert property (frame_open |-> frame_held)
    else $error("select dropped early");
  first_edge_a: assert property (frame_open |-> ##[1:12] $rose(spi_out.sclk))
    else $error("no clock after select");
  ssi_high_a: assert property ($rose(ssi_clk_out) |-> ssi_clk_out [*5])
    else $error("position clock high too short");
  links_apart_a: assert property (!spi_out.cs_n |-> ssi_clk_out)
    else $error("position read during write");
endmodule

bind zero_offset_host zero_offset_host_assertions chk (
  .ref_clk_in(ref_clk_in),
  .rstn_in(rstn_in),
  .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in),
  .avs_waitrequest_out(avs_waitrequest_out),
  .ssi_clk_out(ssi_clk_out),
  .spi_out(spi_out)
);

// ===== sim/encoder_model.sv
// Behavioural encoder: position link and configuration registers
`timescale 1ns/1ps
module encoder_model #(
  parameter int unsigned PROG_CYCLES = 40
) (
  // Clock and control
  input wire logic ref_clk_in,
  input wire logic erase_in,
  input wire logic [4:0] nbits_in,
  input wire logic [24:0] angle_in,
  // Links
  input wire logic ssi_clk_in,
  output logic ssi_data_out,
  input wire zero_ofs_pkg::spi_pins_t spi_in,
  // Observation
  output logic [7:0] frames_out,
  output logic seq_err_out,
  output logic [23:0] ofs_out
);
  import zero_ofs_pkg::*;
  logic [7:0] page;
  logic unlocked;
  logic nv_open;
  logic ssi_busy = 1'b0;
  logic [23:0] shadow;
  logic [15:0] sh;
  logic [4:0] spi_cnt;
  logic [4:0] ssi_cnt;
  logic [24:0] word;
  int prog_timer;
  initial ssi_data_out = 1'b1;
  always @(posedge ref_clk_in)
  begin
    if (erase_in)
    begin
      page <= 8'h00;
      unlocked <= 1'b0;
      nv_open <= 1'b0;
      frames_out <= 8'h00;
      seq_err_out <= 1'b0;
      ofs_out <= 24'h000000;
      prog_timer <= 0;
    end
    else if (prog_timer > 0)
    begin
      prog_timer <= prog_timer - 1;
      if (prog_timer == 1)
        ofs_out <= shadow;
    end
  end
  always @(negedge spi_in.cs_n)
    spi_cnt = 5'h00;
  always @(posedge spi_in.sclk)
    if (!spi_in.cs_n)
    begin
      sh = {sh[14:0], spi_in.mosi};
      spi_cnt = spi_cnt + 5'h01;
    end
  always @(posedge spi_in.cs_n)
  begin
    frames_out <= frames_out + 8'h01;
    if (spi_cnt != 5'h10 || sh[15] != SPI_WR_FLAG)
      seq_err_out <= 1'b1;
    else if (sh[14:8] == PAGE_SEL_ADDR)
      page <= sh[7:0];
    else if (page == PAGE_CFG && sh[14:8] == UNLOCK_ADDR && sh[7:0] == UNLOCK_KEY)
      unlocked <= 1'b1;
    else if (unlocked && page == PAGE_OFS && sh[14:8] == OFS_LOW_ADDR)
      shadow[7:0] <= sh[7:0];
    else if (unlocked && page == PAGE_OFS && sh[14:8] == OFS_MID_ADDR)
      shadow[15:8] <= sh[7:0];
    else if (unlocked && page == PAGE_OFS && sh[14:8] == OFS_HIGH_ADDR)
      shadow[23:16] <= sh[7:0];
    else if (unlocked && sh[14:8] == NV_UNLOCK_ADDR && sh[7:0] == NV_UNLOCK_KEY)
      nv_open <= 1'b1;
    else if (nv_open && sh[14:8] == NV_PROG_ADDR && sh[7:0] == NV_PROG_CMD)
      prog_timer <= PROG_CYCLES;
    else
      seq_err_out <= 1'b1;
  end
  always @(negedge ssi_clk_in)
    if (!ssi_busy)
    begin
      word = (angle_in - {ofs_out, 1'b0}) >> (25 - nbits_in);
      ssi_cnt = 5'h00;
      ssi_busy = 1'b1;
    end
  // Line idles high between frames, like the pulled-up receiver
  always @(posedge ssi_clk_in)
    if (ssi_busy && ssi_cnt < nbits_in)
    begin
      ssi_data_out = word[nbits_in - 5'h01 - ssi_cnt];
      ssi_cnt = ssi_cnt + 5'h01;
    end
    else
    begin
      ssi_busy = 1'b0;
      ssi_data_out = 1'b1;
    end
endmodule

// ===== sim/tb_top.sv
// Testbench for the zero offset programming controller
`timescale 1ns/1ps
module tb_top;
  import zero_ofs_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [3:0] avs_address_in = 4'h0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0] avs_byteenable_in = 4'hF;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic ssi_clk_out;
  logic ssi_data_in;
  spi_pins_t spi_out;
  logic erase = 1'b1;
  logic [4:0] nbits = NBITS_25;
  logic [24:0] angle = 25'h0;
  logic [7:0] frames;
  logic seq_err;
  logic [23:0] dev_ofs;
  logic [31:0] rd_val;
  logic [24:0] masked;
  logic [4:0] nb_tab [4] = '{NBITS_25, NBITS_23, NBITS_21, NBITS_17};
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  always #50 ref_clk_in = ~ref_clk_in;
  zero_offset_host #(.PROG_WAIT_CYCLES(50), .SSI_RECOVERY_CYCLES(5)) dut (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .ssi_clk_out(ssi_clk_out),
    .ssi_data_in(ssi_data_in),
    .spi_out(spi_out)
  );
  encoder_model #(.PROG_CYCLES(40)) dev (
    .ref_clk_in(ref_clk_in),
    .erase_in(erase),
    .nbits_in(nbits),
    .angle_in(angle),
    .ssi_clk_in(ssi_clk_out),
    .ssi_data_out(ssi_data_in),
    .spi_in(spi_out),
    .frames_out(frames),
    .seq_err_out(seq_err),
    .ofs_out(dev_ofs)
  );
  task automatic final_report;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge; data taken there
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do
      @(posedge ref_clk_in);
    while (avs_waitrequest_out !== 1'b0);
    rd_val = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      num_errors++;
      final_report;
    end
  end
  initial
  begin
    repeat (10) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    erase <= 1'b0;
    @(posedge ref_clk_in);
    for (int a = 0; a < 16; a += 4)
    begin
      bus(1'b0, a[3:0], 32'h0);
      check("reset value", rd_val, 32'h0);
    end
    avs_byteenable_in <= 4'h0;
    bus(1'b1, REG_CTRL, 32'h32);
    avs_byteenable_in <= 4'hF;
    bus(1'b1, 4'h1, 32'h32);
    bus(1'b0, REG_CTRL, 32'h0);
    check("ctrl kept", rd_val, 32'h0);
    bus(1'b0, 4'h3, 32'h0);
    check("unmapped", rd_val, 32'h0);
    bus(1'b1, REG_CTRL, 32'h1);
    bus(1'b0, REG_STATUS, 32'h0);
    check("refused", rd_val, 32'h4);
    check("no frames", 32'(frames), 32'h0);
    bus(1'b1, REG_STATUS, 32'h4);
    bus(1'b0, REG_STATUS, 32'h0);
    check("refused clear", rd_val, 32'h0);
    for (int r = 0; r < 4; r++)
    begin
      erase <= 1'b1;
      nbits <= nb_tab[r];
      angle <= 25'h1ABCDE6 + 25'(r << 12);
      @(posedge ref_clk_in);
      erase <= 1'b0;
      masked = ((angle >> (25 - nbits)) << (25 - nbits));
      bus(1'b1, REG_CTRL, 32'h3 | (32'(r) << 4));
      if (r == 0)
        bus(1'b1, REG_CTRL, 32'h3);
      bus(1'b0, REG_CTRL, 32'h0);
      check("ctrl", rd_val, 32'h2 | (32'(r) << 4));
      // Status is polled at least once; the ctrl read left the still bit in rd_val
      n = 0;
      do
      begin
        bus(1'b0, REG_STATUS, 32'h0);
        n++;
      end
      while (rd_val[1] !== 1'b1 && n < 2000);
      check("status", rd_val, 32'hA);
      bus(1'b0, REG_OFFSET, 32'h0);
      check("offset", rd_val, {8'h00, masked[24:1]});
      bus(1'b0, REG_POSITION, 32'h0);
      check("position", rd_val, 32'h0);
      check("device offset", 32'(dev_ofs), {8'h00, masked[24:1]});
      check("frames", 32'(frames), 32'h8);
      check("order", 32'(seq_err), 32'h0);
      bus(1'b1, REG_STATUS, 32'h2);
    end
    final_report;
  end
endmodule
